// ---- design/ssw_params.svh ----
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH

// ======================================================================
// Time base
`define SSW_CLK_HZ 64'h0000_0000_0BEB_C200
`define SSW_CNT_WIDTH 36

// ======================================================================
// Times as specified and their cycle counts
`define SSW_RST_TIMEOUT_MS 64'd140
`define SSW_WDOG_TIMEOUT_MS 64'd1600
`define SSW_STARTUP_S 64'd54
`define SSW_RST_TIMEOUT_CYC \
   ((`SSW_RST_TIMEOUT_MS * `SSW_CLK_HZ + 64'd999) / 64'd1000)
`define SSW_WDOG_TIMEOUT_CYC \
   ((`SSW_WDOG_TIMEOUT_MS * `SSW_CLK_HZ) / 64'd1000)
`define SSW_STARTUP_CYC (`SSW_STARTUP_S * `SSW_CLK_HZ)

// ======================================================================
// Register offsets
`define SSW_ADDR_CAP_TIMEOUT 8'h00
`define SSW_ADDR_STATUS 8'h04
`define SSW_ADDR_SUPPLY 8'h08

// ======================================================================
// Reset values
`define SSW_CAP_TIMEOUT_RST 32'h0100_0000

// ======================================================================
// Status field positions
`define SSW_ST_RESET 0
`define SSW_ST_FAULT 1
`define SSW_ST_FLOAT 2
`define SSW_ST_STARTUP 3
`define SSW_ST_UNDER 4
`define SSW_ST_TOL 5
`define SSW_ST_MARGIN 6

`endif

// ---- design/ssw_pkg.sv ----
package ssw_pkg;

   // ===================================================================
   // Reset generator states
   typedef enum logic [1:0] {
      SSW_RST_HOLD = 2'b00,
      SSW_RST_COUNT = 2'b01,
      SSW_RST_RELEASED = 2'b10
   } ssw_rst_state_t;

endpackage : ssw_pkg

// ---- design/ssw_sync.sv ----
`timescale 1ns/1ps

// ======================================================================
// Two-stage synchroniser, per-bit reset value
module ssw_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end else begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end

   assign q = q_reg;

endmodule : ssw_sync

// ---- design/ssw_timer.sv ----
`timescale 1ns/1ps

// ======================================================================
// Up counter; done pulses on the last cycle and restarts the count
module ssw_timer #(
   parameter int W = 36
)(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clear,
   input wire logic run,
   input wire logic [W-1:0] limit,
   output logic done
);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   assign done = run && !clear && (cnt_reg == limit - W'(1));

   always_comb begin
      cnt_next = cnt_reg;
      if (clear || done) begin
         cnt_next = '0;
      end else if (run) begin
         cnt_next = cnt_reg + W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

endmodule : ssw_timer

// ---- design/ssw_supervisor.sv ----
// Summary of operation
// - Tolerance select low gives 5%, high gives 10% threshold tolerance
// - Reset-output variant: kick level held past timeout asserts reset
// - Timer clears on any kick edge; reset-output variant also clears it while reset asserted
// - Reset-output variant: 54s startup window after reset for first kick
// - Floating kick input disables the watchdog completely
// - Fault variant: timeout drives fault output; only kick edges and float clear timer
// - Fault variant: no startup window, normal timeout from the start
// - Manual reset low asserts reset; released after full reset timeout
// - Reset asserted while any supply is under threshold or manual reset
// - Reset held for timeout after all causes clear; count restarts
// - Timeout-set high uses internal 140ms timeout, else capacitor value
// - Fault variant: fault output low while any supply is under threshold
// - Fault output releases at once when supplies recover
// - Fault variant, supplies good: fault output asserts on each watchdog expiry
// - Fault output released by a kick edge or manual reset low
// - Watchdog starts counting only after reset timeout following release
// - Margin override low forces fault output high
// - Margin override low forces reset and fault outputs high; tolerance output not forced
`timescale 1ns/1ps
`include "ssw_params.svh"

module ssw_supervisor #(
   parameter int NUM_SUPPLIES = 6,
   parameter bit FAULT_OUT_VARIANT = 1'b0,
   parameter longint unsigned RST_TIMEOUT_CYC = `SSW_RST_TIMEOUT_CYC,
   parameter longint unsigned WDOG_TIMEOUT_CYC = `SSW_WDOG_TIMEOUT_CYC,
   parameter longint unsigned STARTUP_CYC = `SSW_STARTUP_CYC
)(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NUM_SUPPLIES-1:0] supply_under_threshold,
   input wire logic manual_reset_request_n,
   input wire logic margin_override_n,
   input wire logic tolerance_select,
   input wire logic reset_timeout_set,
   input wire logic watchdog_kick_input,
   input wire logic watchdog_kick_float,
   output logic system_reset_n,
   output logic watchdog_fault_n,
   output logic threshold_tol_10pct
);

   localparam int CW = `SSW_CNT_WIDTH;
   localparam int SW = NUM_SUPPLIES + 6;
   localparam longint unsigned CMAX = (64'd1 << CW) - 64'd1;

   // ===================================================================
   // Elaboration checks
   generate
      if (NUM_SUPPLIES < 1 || NUM_SUPPLIES > 32) begin : g_bad_n
         $error("NUM_SUPPLIES must be 1 to 32");
      end
      if (RST_TIMEOUT_CYC < 1 || RST_TIMEOUT_CYC > CMAX ||
          WDOG_TIMEOUT_CYC < 1 || WDOG_TIMEOUT_CYC > CMAX ||
          STARTUP_CYC < 1 || STARTUP_CYC > CMAX) begin : g_bad_cnt
         $error("Timeout counts must fit the counter and be nonzero");
      end
   endgenerate

   // ===================================================================
   // Input synchronisers
   logic [SW-1:0] raw;
   logic [SW-1:0] synced;
   logic [NUM_SUPPLIES-1:0] under_s;
   logic mr_n_s;
   logic margin_n_s;
   logic tol_s;
   logic srt_s;
   logic kick_s;
   logic float_s;

   assign raw = {supply_under_threshold, manual_reset_request_n,
                 margin_override_n, tolerance_select, reset_timeout_set,
                 watchdog_kick_input, watchdog_kick_float};

   ssw_sync #(
      .W(SW),
      .RST_VAL({{NUM_SUPPLIES{1'b0}}, 6'b11_0000})
   ) u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .d(raw),
      .q(synced)
   );

   assign {under_s, mr_n_s, margin_n_s, tol_s, srt_s, kick_s, float_s} =
      synced;

   logic any_under;
   logic mr_active;
   logic margin_active;

   assign any_under = |under_s;
   assign mr_active = !mr_n_s;
   assign margin_active = !margin_n_s;

   // ===================================================================
   // Reset generator
   ssw_pkg::ssw_rst_state_t rst_state_reg;
   ssw_pkg::ssw_rst_state_t rst_state_next;
   logic [31:0] cap_timeout_reg;
   logic [31:0] cap_timeout_next;
   logic [CW-1:0] rst_limit;
   logic rst_cause;
   logic rst_done;
   logic rst_asserted;
   logic wd_done;

   assign rst_cause = any_under || mr_active ||
                      (!FAULT_OUT_VARIANT && wd_done);
   assign rst_asserted = (rst_state_reg != ssw_pkg::SSW_RST_RELEASED);

   always_comb begin
      if (srt_s) begin
         rst_limit = CW'(RST_TIMEOUT_CYC);
      end else if (cap_timeout_reg == 32'h0000_0000) begin
         rst_limit = CW'(1);
      end else begin
         rst_limit = CW'(cap_timeout_reg);
      end
   end

   ssw_timer #(
      .W(CW)
   ) u_rst_timer (
      .core_clk(core_clk),
      .nrst(nrst),
      .clear(rst_cause || (rst_state_reg == ssw_pkg::SSW_RST_HOLD)),
      .run(rst_state_reg == ssw_pkg::SSW_RST_COUNT),
      .limit(rst_limit),
      .done(rst_done)
   );

   always_comb begin
      rst_state_next = rst_state_reg;
      case (rst_state_reg)
         ssw_pkg::SSW_RST_HOLD: begin
            if (!rst_cause) begin
               rst_state_next = ssw_pkg::SSW_RST_COUNT;
            end
         end
         ssw_pkg::SSW_RST_COUNT: begin
            if (rst_cause) begin
               rst_state_next = ssw_pkg::SSW_RST_HOLD;
            end else if (rst_done) begin
               rst_state_next = ssw_pkg::SSW_RST_RELEASED;
            end
         end
         ssw_pkg::SSW_RST_RELEASED: begin
            if (rst_cause) begin
               rst_state_next = ssw_pkg::SSW_RST_HOLD;
            end
         end
         default: begin
            rst_state_next = ssw_pkg::SSW_RST_HOLD;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_state_reg <= ssw_pkg::SSW_RST_HOLD;
      end else begin
         rst_state_reg <= rst_state_next;
      end
   end

   // ===================================================================
   // Watchdog
   logic kick_prev_reg;
   logic kick_prev_next;
   logic startup_reg;
   logic startup_next;
   logic fault_reg;
   logic fault_next;
   logic kick_edge;
   logic wd_run;
   logic wd_clear;
   logic [CW-1:0] wd_limit;

   assign kick_edge = kick_s ^ kick_prev_reg;
   assign wd_run = !float_s &&
                   (rst_state_reg == ssw_pkg::SSW_RST_RELEASED);
   assign wd_clear = kick_edge || float_s ||
                     (!FAULT_OUT_VARIANT && rst_asserted);
   assign wd_limit = startup_reg ? CW'(STARTUP_CYC) :
                     CW'(WDOG_TIMEOUT_CYC);

   ssw_timer #(
      .W(CW)
   ) u_wd_timer (
      .core_clk(core_clk),
      .nrst(nrst),
      .clear(wd_clear),
      .run(wd_run),
      .limit(wd_limit),
      .done(wd_done)
   );

   always_comb begin
      kick_prev_next = kick_s;
      startup_next = startup_reg;
      fault_next = fault_reg;
      if (!FAULT_OUT_VARIANT) begin
         fault_next = 1'b0;
         if (rst_asserted) begin
            startup_next = 1'b1;
         end else if (kick_edge || wd_done) begin
            startup_next = 1'b0;
         end
      end else begin
         startup_next = 1'b0;
         if (kick_edge || mr_active || float_s) begin
            fault_next = 1'b0;
         end
         if (wd_done) begin
            fault_next = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         kick_prev_reg <= 1'b0;
         startup_reg <= !FAULT_OUT_VARIANT;
         fault_reg <= 1'b0;
      end else begin
         kick_prev_reg <= kick_prev_next;
         startup_reg <= startup_next;
         fault_reg <= fault_next;
      end
   end

   // ===================================================================
   // Output pins
   logic sys_rst_n_reg;
   logic sys_rst_n_next;
   logic wdo_n_reg;
   logic wdo_n_next;
   logic tol_reg;
   logic tol_next;

   always_comb begin
      sys_rst_n_next = margin_active ||
                       (rst_state_next == ssw_pkg::SSW_RST_RELEASED);
      if (!FAULT_OUT_VARIANT || margin_active) begin
         wdo_n_next = 1'b1;
      end else begin
         wdo_n_next = !(any_under || fault_next);
      end
      tol_next = tol_s;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sys_rst_n_reg <= 1'b0;
         wdo_n_reg <= 1'b1;
         tol_reg <= 1'b0;
      end else begin
         sys_rst_n_reg <= sys_rst_n_next;
         wdo_n_reg <= wdo_n_next;
         tol_reg <= tol_next;
      end
   end

   assign system_reset_n = sys_rst_n_reg;
   assign watchdog_fault_n = wdo_n_reg;
   assign threshold_tol_10pct = tol_reg;

   // ===================================================================
   // APB slave
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic [31:0] status_word;
   logic [31:0] supply_word;
   logic mapped;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`SSW_ST_RESET] = rst_asserted;
      status_word[`SSW_ST_FAULT] = fault_reg;
      status_word[`SSW_ST_FLOAT] = float_s;
      status_word[`SSW_ST_STARTUP] = startup_reg;
      status_word[`SSW_ST_UNDER] = any_under;
      status_word[`SSW_ST_TOL] = tol_s;
      status_word[`SSW_ST_MARGIN] = margin_active;
      supply_word = 32'h0000_0000;
      supply_word[NUM_SUPPLIES-1:0] = under_s;
   end

   always_comb begin
      pready_next = psel && penable && !pready_reg;
      prdata_next = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         `SSW_ADDR_CAP_TIMEOUT: prdata_next = cap_timeout_reg;
         `SSW_ADDR_STATUS: prdata_next = status_word;
         `SSW_ADDR_SUPPLY: prdata_next = supply_word;
         default: mapped = 1'b0;
      endcase
      if (!pready_next || pwrite) begin
         prdata_next = 32'h0000_0000;
      end
      pslverr_next = pready_next && !mapped;
      cap_timeout_next = cap_timeout_reg;
      if (psel && penable && pready_reg && pwrite &&
          paddr == `SSW_ADDR_CAP_TIMEOUT) begin
         cap_timeout_next = pwdata;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         cap_timeout_reg <= `SSW_CAP_TIMEOUT_RST;
      end else begin
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
         cap_timeout_reg <= cap_timeout_next;
      end
   end

   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign prdata = prdata_reg;

endmodule : ssw_supervisor

// ---- tb/ssw_monitor.sv ----
`timescale 1ns/1ps
// ==========
// Port checker
module ssw_monitor #(
   parameter int N = 6,
   parameter longint unsigned RST = 50,
   parameter longint unsigned WDOG = 200,
   parameter bit FV = 1'b1
)(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic [N-1:0] supply_under_threshold,
   input wire logic manual_reset_request_n,
   input wire logic margin_override_n,
   input wire logic tolerance_select,
   input wire logic reset_timeout_set,
   input wire logic watchdog_kick_input,
   input wire logic watchdog_kick_float,
   input wire logic system_reset_n,
   input wire logic watchdog_fault_n,
   input wire logic threshold_tol_10pct
);
   logic [15:0] good_reg, good_next, still_reg, still_next;
   logic [3:0] mg_reg, mg_next;
   logic kick_reg;
   logic any_under, calm;
   assign any_under = |supply_under_threshold;
   assign calm = &mg_reg && margin_override_n;
   // ==========
   // Cycles without cause, cycles since kick change
   always_comb begin
      good_next = '0;
      if (manual_reset_request_n && !any_under)
         good_next = good_reg + 16'h0001;
      still_next = still_reg + 16'h0001;
      if (watchdog_kick_input != kick_reg)
         still_next = '0;
      mg_next = {mg_reg[2:0], margin_override_n};
   end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         good_reg <= '0;
         still_reg <= '0;
         mg_reg <= '0;
         kick_reg <= 1'h0;
      end else begin
         good_reg <= good_next;
         still_reg <= still_next;
         mg_reg <= mg_next;
         kick_reg <= watchdog_kick_input;
      end
   end
   // ==========
   // Properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence s_down;
      (any_under && !manual_reset_request_n)[*4];
   endsequence
   sequence s_up;
      (!any_under && !manual_reset_request_n)[*4];
   endsequence
   AST_TOL: assert property (
      $stable(tolerance_select)[*4] |->
      threshold_tol_10pct == tolerance_select)
      else $error("tolerance copy wrong");
   AST_MARGIN: assert property (
      (!margin_override_n)[*4] |-> system_reset_n && watchdog_fault_n)
      else $error("margin did not release outputs");
   AST_UNDER: assert property (
      (any_under && margin_override_n)[*5] |->
      !system_reset_n && (!watchdog_fault_n || !FV))
      else $error("under supply not reported");
   AST_MANUAL: assert property (
      (!manual_reset_request_n && margin_override_n)[*5] |->
      !system_reset_n)
      else $error("manual reset not asserted");
   AST_STRETCH: assert property (
      $rose(system_reset_n) && calm && reset_timeout_set |->
      good_reg >= RST)
      else $error("reset released early");
   AST_RECOVER: assert property (
      s_down ##1 s_up |=> watchdog_fault_n)
      else $error("fault output stretched");
   AST_WDOG_MIN: assert property (
      $fell(watchdog_fault_n) && calm && good_reg > 16'h0008 |->
      still_reg >= WDOG)
      else $error("watchdog expired early");
   AST_FLOAT: assert property (
      (watchdog_kick_float && !any_under)[*6] |-> watchdog_fault_n)
      else $error("fault while watchdog disabled");
   AST_APB_WAIT: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("bus answer timing wrong");
endmodule : ssw_monitor

// ---- tb/ssw_host.sv ----
`timescale 1ns/1ps
// ==========
// Host: toggles kick every PER cycles while run
module ssw_host #(
   parameter int PER = 40
)(
   input wire logic core_clk,
   input wire logic run,
   output logic kick
);
   int c = 0;
   initial kick = 1'h0;
   always @(posedge core_clk) begin
      c <= run ? c + 1 : 0;
      if (run && c == PER - 1) begin
         c <= 0;
         kick <= ~kick;
      end
   end
endmodule : ssw_host

// ---- tb/ssw_supervisor_test.sv ----
`timescale 1ns/1ps
module ssw_supervisor_test;
   localparam int RST = 50;
   localparam int WDOG = 200;
   localparam int PER = 40;
   localparam logic [31:0] HI = 32'h0000_0001;
   localparam logic [31:0] LO = 32'h0000_0000;
   logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] under;
   logic man_n, mg_n, tsel, rts, flt, run, kick, k0;
   logic rst_n, fault_n, tol10, rst0_n;
   int fails = 0;
   int cmp_count = 0;
   int n;
   ssw_supervisor #(.FAULT_OUT_VARIANT(1'b1), .RST_TIMEOUT_CYC(RST),
      .WDOG_TIMEOUT_CYC(WDOG), .STARTUP_CYC(600)) i_ssw_supervisor (
      .core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .supply_under_threshold(under),
      .manual_reset_request_n(man_n), .margin_override_n(mg_n),
      .tolerance_select(tsel), .reset_timeout_set(rts),
      .watchdog_kick_input(kick), .watchdog_kick_float(flt),
      .system_reset_n(rst_n), .watchdog_fault_n(fault_n),
      .threshold_tol_10pct(tol10));
   ssw_supervisor #(.FAULT_OUT_VARIANT(1'b0), .RST_TIMEOUT_CYC(RST),
      .WDOG_TIMEOUT_CYC(WDOG), .STARTUP_CYC(600)) i_ssw_supervisor_v0 (
      .core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata(), .pready(), .pslverr(), .supply_under_threshold(under),
      .manual_reset_request_n(man_n), .margin_override_n(mg_n),
      .tolerance_select(tsel), .reset_timeout_set(rts),
      .watchdog_kick_input(kick), .watchdog_kick_float(flt),
      .system_reset_n(rst0_n), .watchdog_fault_n(),
      .threshold_tol_10pct());
   ssw_host #(.PER(PER)) i_ssw_host (.core_clk, .run, .kick);
   // ==========
   // Helpers
   task wt(input int k);
      repeat (k) @(posedge core_clk);
   endtask : wt
   task chk(input logic [31:0] v, input logic [31:0] e);
      cmp_count++;
      if (v !== e) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, v, e);
      end
   endtask : chk
   task wfault;
      for (n = 0; n < 400 && fault_n !== 1'h0; n++)
         wt(1);
   endtask : wfault
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      while (pready !== 1'h1)
         @(posedge core_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task end_sim;
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   // ==========
   // Scenarios
   task t_boot;
      wt(40);
      chk(32'(rst_n), LO);
      for (n = 0; n < 60 && rst_n !== 1'h1; n++)
         wt(1);
      chk(32'(rst_n), HI);
      wfault;
      chk(32'(n >= WDOG - 5 && n <= WDOG + 10), HI);
      chk(32'(rst0_n), HI);
      run <= 1'h1;
      wt(PER + 20);
      chk(32'(fault_n), HI);
   endtask : t_boot
   task t_apb;
      apb(1'h0, 8'h00, LO);
      chk(rd, 32'h0100_0000);
      apb(1'h0, 8'h0C, LO);
      chk(32'(er), HI);
      apb(1'h1, 8'h00, 32'h0000_000A);
      apb(1'h0, 8'h00, LO);
      chk(rd, 32'h0000_000A);
   endtask : t_apb
   task t_tol;
      tsel <= 1'h1;
      wt(5);
      chk(32'(tol10), HI);
      tsel <= 1'h0;
      wt(5);
      chk(32'(tol10), LO);
   endtask : t_tol
   task t_wdog;
      wt(300);
      chk(32'(fault_n), HI);
      k0 = kick;
      for (n = 0; n < 60 && kick === k0; n++)
         wt(1);
      run <= 1'h0;
      wfault;
      chk(32'(n >= WDOG && n <= WDOG + 12), HI);
      chk(32'(rst_n), HI);
      chk(32'(rst0_n), LO);
      run <= 1'h1;
      wt(PER + 8);
      chk(32'(fault_n), HI);
      run <= 1'h0;
      wfault;
      chk(32'(fault_n), LO);
      man_n <= 1'h0;
      wt(10);
      chk(32'(fault_n), HI);
      chk(32'(rst_n), LO);
      man_n <= 1'h1;
      wfault;
      chk(32'(n >= RST + WDOG - 15 && n <= RST + WDOG + 15), HI);
      chk(32'(rst0_n), HI);
      run <= 1'h1;
      wt(PER + 8);
   endtask : t_wdog
   task t_under;
      under <= 6'h08;
      wt(6);
      chk(32'({rst_n, fault_n}), LO);
      mg_n <= 1'h0;
      wt(5);
      chk(32'({rst_n, fault_n}), 32'h0000_0003);
      mg_n <= 1'h1;
      man_n <= 1'h0;
      wt(6);
      under <= 6'h00;
      wt(5);
      chk(32'({rst_n, fault_n}), HI);
      man_n <= 1'h1;
      wt(RST + 10);
      chk(32'(rst_n), HI);
   endtask : t_under
   task t_float;
      run <= 1'h0;
      flt <= 1'h1;
      wt(WDOG * 2);
      chk(32'({rst_n, fault_n}), 32'h0000_0003);
      flt <= 1'h0;
      run <= 1'h1;
      wt(PER + 8);
   endtask : t_float
   task t_cap;
      rts <= 1'h0;
      man_n <= 1'h0;
      wt(6);
      man_n <= 1'h1;
      wt(25);
      chk(32'(rst_n), HI);
   endtask : t_cap
   // ==========
   // Clock, sequence, watchdog
   initial begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      nrst = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = '0;
      pwdata = '0;
      under = '0;
      man_n = 1'h1;
      mg_n = 1'h1;
      tsel = 1'h0;
      rts = 1'h1;
      flt = 1'h0;
      run = 1'h0;
      wt(6);
      nrst <= 1'h1;
      t_boot;
      t_apb;
      t_tol;
      t_wdog;
      t_under;
      t_float;
      t_cap;
      end_sim;
   end
   initial begin
      wt(10000);
      fails++;
      end_sim;
   end
endmodule : ssw_supervisor_test
bind ssw_supervisor ssw_monitor #(.N(NUM_SUPPLIES),
   .RST(RST_TIMEOUT_CYC), .WDOG(WDOG_TIMEOUT_CYC),
   .FV(FAULT_OUT_VARIANT)) i_ssw_monitor (
   .core_clk, .nrst, .psel, .penable, .pready, .supply_under_threshold,
   .manual_reset_request_n, .margin_override_n, .tolerance_select,
   .reset_timeout_set, .watchdog_kick_input, .watchdog_kick_float,
   .system_reset_n, .watchdog_fault_n, .threshold_tol_10pct);
